// file: logic/irsd_codec.sv
`timescale 1ns/100ps
// Summary of operation
// - Enable bit turns on encode and decode
// - Link is not half-duplex, runs both ways at once
// - Bit timing comes from baud tick
// - One bit: output low sixteen clocks
// - Zero bit: low 7, high 3, low 6
// - Decoder runs only with receive enable set
// - Steady high input decodes as one
// - Low pulse after high decodes as zero
// - Input sampled once per baud tick
// - After first bit, decoded bits sixteen wide
// - Internal loopback feeds inverted output back
// - Decoder keeps receiving during transmission
// - Unused bits ignore writes, read zero
// - Control resets to zero, bits 2..0 writable
// - Bit 2 selects internal loopback
// - Bit 1 gates received data to serial port
module irsd_codec (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Register port
    input wire logic [irsd_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [irsd_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [irsd_pkg::DATA_W-1:0] reg_rdata,
    // Serial port side
    input wire logic baud_tick,
    input wire logic uart_txd,
    output logic uart_rxd,
    // Transceiver pins
    output logic infrared_pulse_out,
    input wire logic infrared_pulse_in
);
    import irsd_pkg::*;

    function automatic logic [PHASE_W-1:0] phase_step(input logic [PHASE_W-1:0] ph);
        phase_step = ph + PH_ONE;
    endfunction

    function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                      input logic [ADDR_W-1:0] off);
        addr_hit = (a == off);
    endfunction

    irsd_ctrl_type ctrl_ff;
    irsd_ctrl_type nxt_ctrl;
    logic [DATA_W-1:0] rdata_ff;
    logic [DATA_W-1:0] nxt_rdata;
    irsd_status_type status;

    logic tx_bit_ff;
    logic nxt_tx_bit;
    logic [PHASE_W-1:0] tx_phase_ff;
    logic [PHASE_W-1:0] nxt_tx_phase;
    logic pulse_out_ff;
    logic nxt_pulse_out;

    logic rx_pin_sync;
    logic rx_src;
    logic rx_fall;
    logic rx_on;
    logic rx_prev_ff;
    logic nxt_rx_prev;
    logic [PHASE_W-1:0] rx_phase_ff;
    logic [PHASE_W-1:0] nxt_rx_phase;
    logic rx_window_ff;
    logic nxt_rx_window;
    logic rxd_ff;
    logic nxt_rxd;

    // Receiver output of the transceiver is active low, so it idles high
    irsd_sync #(
        .RST_VAL(LINE_IDLE)
    ) u_rx_sync (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .async_in(infrared_pulse_in),
        .sync_out(rx_pin_sync)
    );

    // Control and read-back
    always_comb begin
        status = '{rx_level: rxd_ff, rx_window: rx_window_ff, tx_zero: !tx_bit_ff};
        nxt_ctrl = ctrl_ff;
        if (reg_wr && addr_hit(reg_addr, CTRL_OFFSET)) begin
            nxt_ctrl = irsd_ctrl_type'(reg_wdata[CTRL_W-1:0]);
        end
        nxt_rdata = READ_IDLE;
        if (reg_rd) begin
            if (addr_hit(reg_addr, CTRL_OFFSET)) begin
                nxt_rdata = DATA_W'(ctrl_ff);
            end else if (addr_hit(reg_addr, STATUS_OFFSET)) begin
                nxt_rdata = DATA_W'(status);
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_ff <= irsd_ctrl_type'(CTRL_RESET[CTRL_W-1:0]);
            rdata_ff <= READ_IDLE;
        end else begin
            ctrl_ff <= nxt_ctrl;
            rdata_ff <= nxt_rdata;
        end
    end

    // Encoder: phase restarts whenever the serial bit changes at a tick,
    // so it follows the serial port's bit grid without knowing its divider
    always_comb begin
        nxt_tx_bit = tx_bit_ff;
        nxt_tx_phase = tx_phase_ff;
        if (!ctrl_ff.codec_enable) begin
            nxt_tx_bit = LINE_IDLE;
            nxt_tx_phase = PH_ZERO;
        end else if (baud_tick) begin
            nxt_tx_bit = uart_txd;
            if (uart_txd != tx_bit_ff) begin
                nxt_tx_phase = PH_ZERO;
            end else begin
                nxt_tx_phase = phase_step(tx_phase_ff);
            end
        end
        nxt_pulse_out = ctrl_ff.codec_enable && !tx_bit_ff
            && (tx_phase_ff >= PH_PULSE_FIRST) && (tx_phase_ff < PH_PULSE_END);
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tx_bit_ff <= LINE_IDLE;
            tx_phase_ff <= PH_ZERO;
            pulse_out_ff <= PULSE_IDLE;
        end else begin
            tx_bit_ff <= nxt_tx_bit;
            tx_phase_ff <= nxt_tx_phase;
            pulse_out_ff <= nxt_pulse_out;
        end
    end

    // Decoder source: in loopback the pin is not looked at at all,
    // which keeps the transceiver's echo out of the test path
    assign rx_src = ctrl_ff.loop_back ? !pulse_out_ff : rx_pin_sync;
    // Transmit activity does not gate the decoder, so the external echo works
    assign rx_on = ctrl_ff.codec_enable && ctrl_ff.receive_decoder_enable;
    assign rx_fall = rx_prev_ff && !rx_src;

    // Each falling edge seen at a tick opens a zero window of one bit time.
    // Pulses narrower than a tick period can be missed entirely.
    always_comb begin
        nxt_rx_prev = rx_prev_ff;
        nxt_rx_phase = rx_phase_ff;
        nxt_rx_window = rx_window_ff;
        nxt_rxd = rxd_ff;
        if (!rx_on) begin
            nxt_rx_prev = LINE_IDLE;
            nxt_rx_phase = PH_ZERO;
            nxt_rx_window = 1'b0;
            nxt_rxd = LINE_IDLE;
        end else if (baud_tick) begin
            nxt_rx_prev = rx_src;
            if (rx_fall) begin
                nxt_rx_window = 1'b1;
                nxt_rx_phase = PH_ZERO;
                nxt_rxd = 1'b0;
            end else if (rx_window_ff) begin
                if (rx_phase_ff == PH_LAST) begin
                    nxt_rx_window = 1'b0;
                    nxt_rx_phase = PH_ZERO;
                    nxt_rxd = LINE_IDLE;
                end else begin
                    nxt_rx_phase = phase_step(rx_phase_ff);
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rx_prev_ff <= LINE_IDLE;
            rx_phase_ff <= PH_ZERO;
            rx_window_ff <= 1'b0;
            rxd_ff <= LINE_IDLE;
        end else begin
            rx_prev_ff <= nxt_rx_prev;
            rx_phase_ff <= nxt_rx_phase;
            rx_window_ff <= nxt_rx_window;
            rxd_ff <= nxt_rxd;
        end
    end

    assign reg_rdata = rdata_ff;
    assign uart_rxd = rxd_ff;
    assign infrared_pulse_out = pulse_out_ff;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    property p_ctrl_write;
        reg_wr && addr_hit(reg_addr, CTRL_OFFSET)
            |=> ctrl_ff == irsd_ctrl_type'($past(reg_wdata[CTRL_W-1:0]));
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

    property p_ctrl_read;
        reg_rd && addr_hit(reg_addr, CTRL_OFFSET)
            |=> reg_rdata[DATA_W-1:CTRL_W] == '0 && reg_rdata[CTRL_W-1:0] == $past(ctrl_ff);
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("control read wrong");

    property p_disabled_quiet;
        !ctrl_ff.codec_enable |=> !infrared_pulse_out ##1 !infrared_pulse_out;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) else $error("pulse while disabled");

    property p_one_no_pulse;
        tx_bit_ff |=> !infrared_pulse_out;
    endproperty
    a_one_no_pulse: assert property (p_one_no_pulse) else $error("pulse on a one bit");

    property p_pulse_start;
        $rose(infrared_pulse_out) |-> $past(tx_phase_ff) == PH_PULSE_FIRST && !$past(tx_bit_ff);
    endproperty
    a_pulse_start: assert property (p_pulse_start) else $error("pulse starts off phase");

    property p_pulse_end;
        $fell(infrared_pulse_out) && $past(ctrl_ff.codec_enable) && $past(tx_phase_ff) != PH_ZERO
            |-> $past(tx_phase_ff) == PH_PULSE_END;
    endproperty
    a_pulse_end: assert property (p_pulse_end) else $error("pulse width not three");

    // Only the cycle after a gated one is tied down: re-enabling may decode at once
    property p_rx_gated;
        !ctrl_ff.receive_decoder_enable |=> uart_rxd && !rx_window_ff;
    endproperty
    a_rx_gated: assert property (p_rx_gated) else $error("receive data while gated");

    property p_zero_width;
        $rose(uart_rxd) && $past(rx_on) |-> $past(rx_phase_ff) == PH_LAST && $past(baud_tick);
    endproperty
    a_zero_width: assert property (p_zero_width) else $error("decoded zero not 16 clocks");

    property p_zero_start;
        $fell(uart_rxd) |-> $past(baud_tick) && $past(rx_prev_ff) && !$past(rx_src);
    endproperty
    a_zero_start: assert property (p_zero_start) else $error("zero without low pulse");

    // A pulse on the way out must come back as a decoded zero one clock after the tick that samples it
    property p_loopback;
        ctrl_ff.loop_back && rx_on && baud_tick && rx_prev_ff && infrared_pulse_out
            |=> !uart_rxd;
    endproperty
    a_loopback: assert property (p_loopback) else $error("loopback path broken");

    property p_window_low;
        rx_window_ff |-> !uart_rxd;
    endproperty
    a_window_low: assert property (p_window_low) else $error("window open, line high");

endmodule

// file: include/irsd_pkg.sv
package irsd_pkg;

    // Register port
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam logic [15:0] CTRL_OFFSET = 16'h00BF;
    localparam logic [15:0] STATUS_OFFSET = 16'h0100;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] READ_IDLE = 8'h00;

    // Bit timing in baud clocks
    localparam int BIT_CLOCKS = 16;
    localparam int PULSE_START = 7;
    localparam int PULSE_CLOCKS = 3;
    localparam int TAIL_CLOCKS = 6;
    localparam int PHASE_W = $clog2(BIT_CLOCKS);
    localparam logic [PHASE_W-1:0] PH_ZERO = 4'h0;
    localparam logic [PHASE_W-1:0] PH_ONE = 4'h1;
    localparam logic [PHASE_W-1:0] PH_PULSE_FIRST = PHASE_W'(PULSE_START);
    localparam logic [PHASE_W-1:0] PH_PULSE_END = PHASE_W'(PULSE_START + PULSE_CLOCKS);
    localparam logic [PHASE_W-1:0] PH_LAST =
        PHASE_W'(PULSE_START + PULSE_CLOCKS + TAIL_CLOCKS - 1);

    // Line levels
    localparam logic LINE_IDLE = 1'b1;
    localparam logic PULSE_IDLE = 1'b0;

    typedef struct packed {
        logic loop_back;
        logic receive_decoder_enable;
        logic codec_enable;
    } irsd_ctrl_type;

    typedef struct packed {
        logic rx_level;
        logic rx_window;
        logic tx_zero;
    } irsd_status_type;

    localparam int CTRL_W = $bits(irsd_ctrl_type);

endpackage

// file: logic/irsd_sync.sv
`timescale 1ns/100ps
module irsd_sync #(
    parameter logic RST_VAL = 1'b1
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Level in and out
    input wire logic async_in,
    output logic sync_out
);
    logic meta_ff;
    logic hold_ff;

    // The first stage feeds only the second one
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            meta_ff <= RST_VAL;
            hold_ff <= RST_VAL;
        end else begin
            meta_ff <= async_in;
            hold_ff <= meta_ff;
        end
    end

    assign sync_out = hold_ff;
endmodule

// file: verif/irsd_xcvr_model.sv
`timescale 1ns/100ps
module irsd_xcvr_model (
    // Clock and bit timing
    input wire logic sys_clk,
    input wire logic baud_tick,
    // Test controls
    input wire logic echo,
    input wire logic send_zero,
    // Transceiver pins
    input wire logic infrared_pulse_out,
    output logic infrared_pulse_in
);
    logic [3:0] phase_ff;

    always_ff @(posedge sys_clk) begin
        if (!send_zero) begin
            phase_ff <= 4'h0;
        end else if (baud_tick) begin
            phase_ff <= phase_ff + 4'h1;
        end
    end

    // Receiver output is active low; echo models light bouncing back off a surface
    always_comb begin
        if (echo) begin
            infrared_pulse_in = !infrared_pulse_out;
        end else begin
            infrared_pulse_in = !(send_zero && phase_ff >= 4'h7 && phase_ff <= 4'h9);
        end
    end
endmodule

// file: verif/irsd_codec_tb.sv
`timescale 1ns/100ps
module irsd_codec_tb;
    import irsd_pkg::*;
    localparam int TICK_DIV = 4;
    localparam int LIMIT = 5000;
    logic sys_clk;
    logic nrst;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [DATA_W-1:0] reg_rdata;
    logic baud_tick;
    logic uart_txd;
    logic uart_rxd;
    logic infrared_pulse_out;
    logic infrared_pulse_in;
    logic echo;
    logic send_zero;
    logic [1:0] div_ff;
    int fail_count;
    int n_tests;
    int cycles;

    irsd_codec u_dut (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .baud_tick(baud_tick), .uart_txd(uart_txd), .uart_rxd(uart_rxd),
        .infrared_pulse_out(infrared_pulse_out), .infrared_pulse_in(infrared_pulse_in));

    // Both pins wired straight to the transceiver; no modem-control pins are modelled
    irsd_xcvr_model u_xcvr (.sys_clk(sys_clk), .baud_tick(baud_tick), .echo(echo),
        .send_zero(send_zero), .infrared_pulse_out(infrared_pulse_out),
        .infrared_pulse_in(infrared_pulse_in));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Fast baud tick keeps each bit at 64 clocks so the run stays short
    // Serial port counts as enabled from reset, so its tick is always running
    always @(posedge sys_clk) begin
        div_ff <= div_ff + 2'h1;
        baud_tick <= (div_ff == 2'(TICK_DIV - 1));
        cycles = cycles + 1;
        if (cycles == LIMIT) begin
            fail_count = fail_count + 1;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("Checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic reg_write(input logic [15:0] addr, input logic [7:0] data);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= addr;
        reg_wdata <= data;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [15:0] addr, output logic [7:0] data);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= addr;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        data = reg_rdata;
    endtask

    task automatic test_registers();
        logic [7:0] rd;
        reg_read(CTRL_OFFSET, rd);
        check("ctrl reset", rd, 8'h00);
        reg_write(CTRL_OFFSET, 8'hff);
        reg_read(CTRL_OFFSET, rd);
        check("ctrl unused bits", rd, 8'h07);
        reg_write(16'h0000, 8'h00);
        reg_read(16'h0000, rd);
        check("unmapped", rd, 8'h00);
        reg_read(CTRL_OFFSET, rd);
        check("ctrl kept", rd, 8'h07);
        reg_read(STATUS_OFFSET, rd);
        check("status idle", rd, 8'h04);
    endtask

    // Sends nbits serial bits, then idles two bits; counts pulse clocks and low rx clocks
    task automatic xfer(input string name, input logic [7:0] ctrl, input logic txd,
                        input logic zro, input int nbits, input int exp_hi, input int exp_lo);
        int hi;
        int lo;
        hi = 0;
        lo = 0;
        reg_write(CTRL_OFFSET, ctrl);
        do @(posedge sys_clk); while (baud_tick !== 1'b1);
        for (int t = 0; t < nbits * 16 + 32; t++) begin
            uart_txd <= (t < nbits * 16) ? txd : 1'b1;
            send_zero <= zro && (t < nbits * 16);
            repeat (TICK_DIV) begin
                @(posedge sys_clk);
                hi += (infrared_pulse_out === 1'b1);
                lo += (uart_rxd === 1'b0);
            end
        end
        check({name, " pulse clocks"}, hi, exp_hi);
        check({name, " rx low clocks"}, lo, exp_lo);
    endtask

    initial begin
        nrst = 1'b0;
        reg_addr = 16'h0000;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        baud_tick = 1'b0;
        uart_txd = 1'b1;
        echo = 1'b0;
        send_zero = 1'b0;
        div_ff = 2'h0;
        fail_count = 0;
        n_tests = 0;
        cycles = 0;
        repeat (3) @(posedge sys_clk);
        nrst <= 1'b1;
        test_registers();
        xfer("disabled", 8'h00, 1'b0, 1'b1, 2, 0, 0);
        xfer("tx zeros", 8'h01, 1'b0, 1'b1, 2, 24, 0);
        xfer("tx ones", 8'h01, 1'b1, 1'b0, 2, 0, 0);
        xfer("rx zeros", 8'h03, 1'b1, 1'b1, 2, 0, 128);
        xfer("rx ones", 8'h03, 1'b1, 1'b0, 2, 0, 0);
        xfer("int loop", 8'h07, 1'b0, 1'b0, 2, 24, 128);
        echo <= 1'b1;
        xfer("ext loop", 8'h03, 1'b0, 1'b0, 1, 12, 64);
        complete_run();
    end
endmodule
